// [tb/tb_wdh_watchdog.sv]
// testbench for the halt-aware watchdog
`include "wdh_consts.vh"
module tb_wdh_watchdog;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [7:0] CTL = {`WDH_IDX_CONTROL, 2'b00};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ie = 1'b0;
  logic        hro = 1'b0;
  logic        hwo = 1'b0;
  logic        lng = 1'b0;
  wire [3:0]   sel;
  wire         cyc;
  wire         we;
  wire         ack;
  wire         pin_n;
  wire         counting;
  wire [7:0]   adr;
  wire [31:0]  wdata;
  wire [31:0]  rdata;
  wire [2:0]   ev;
  int          n_fail = 0;
  int          n_compared = 0;
  int          c;
  logic [7:0]  v;
  logic [7:0]  w;
  wdh_watchdog #(.PRESCALE(16)) u_wdh_watchdog (
    .CORE_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdata), .WB_DAT_O(rdata), .WB_ACK_O(ack),
    .HALT_EXEC(ev[0]), .EXT_IRQ_WAKE(ev[1]), .OSC_IRQ_WAKE(ev[2]),
    .TIMEBASE_IRQ_ENABLE(ie), .HALT_RESET_OPTION(hro), .HW_WATCHDOG_OPTION(hwo),
    .RESUME_DELAY_LONG(lng), .RESET_PIN_N(pin_n), .WDG_COUNTING(counting));
  wdh_cpu_model u_wdh_cpu_model (.clk(clk), .ack(ack), .rdata(rdata), .cyc(cyc),
    .we(we), .adr(adr), .wdata(wdata), .sel(sel), .ev(ev));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && n_compared > 0 && !u_wdh_cpu_model.lost)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_rst(input logic hw);
    nrst <= 1'b0;
    hwo <= hw;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
  endtask
  // bounded wait until the reset pin (sel 1) or counting flag (sel 0) shows lvl
  task automatic wt(input logic sel, input logic lvl, input int n);
    c = 0;
    while ((sel ? pin_n : counting) !== lvl && c < n) begin
      @(posedge clk);
      c++;
    end
    // a wait that runs out is a mismatch
    if ((sel ? pin_n : counting) !== lvl) n_fail++;
  endtask
  task automatic rw(input logic wr, input [7:0] a, input [7:0] d);
    u_wdh_cpu_model.xfer(wr, a, d, v);
  endtask
  initial begin
    do_rst(1'b0);
    rw(1'b0, CTL, 8'h0);
    chk("control reset", `WDH_CTL_RESET, v);
    wt(1'b0, 1'b1, 6000);
    chk("resume delay", 8'h1, 8'(c >= 244 && c <= 264));
    rw(1'b0, 8'hf0, 8'h0);
    chk("unmapped read", 8'h0, v);
    repeat (40) @(posedge clk);
    rw(1'b0, CTL, 8'h0);
    chk("free count", 8'h1, 8'(v < 8'h7f && v > 8'h7b && pin_n === 1'b1));
    ie <= 1'b1;
    u_wdh_cpu_model.halt(8'hff);
    repeat (40) @(posedge clk);
    rw(1'b0, CTL, 8'h0);
    w = v;
    repeat (80) @(posedge clk);
    rw(1'b0, CTL, 8'h0);
    chk("clocked halt hold", w, v);
    chk("clocked halt idle", 8'h0, 8'(counting === 1'b1 || pin_n === 1'b0));
    u_wdh_cpu_model.pulse(3'b100);
    @(posedge clk);
    chk("osc wake", 8'h1, 8'(counting === 1'b1));
    ie <= 1'b0;
    u_wdh_cpu_model.halt(8'hff);
    repeat (40) @(posedge clk);
    rw(1'b0, CTL, 8'h0);
    w = v;
    repeat (80) @(posedge clk);
    rw(1'b0, CTL, 8'h0);
    chk("plain halt", 8'h1, 8'(v === w && (w === 8'hfe || w === 8'hfd) && pin_n));
    lng <= 1'b1;
    u_wdh_cpu_model.pulse(3'b010);
    wt(1'b0, 1'b1, 6000);
    chk("ext wake delay", 8'h1, 8'(c >= 4090 && c <= 4106));
    lng <= 1'b0;
    u_wdh_cpu_model.halt(8'hff);
    do_rst(1'b0);
    wt(1'b0, 1'b1, 6000);
    rw(1'b1, CTL, 8'h41);
    c = 0;
    repeat (80) begin
      @(posedge clk);
      c += (pin_n !== 1'b1);
    end
    chk("disabled after reset", 8'h0, 8'(c));
    rw(1'b1, CTL, 8'hc2);
    rw(1'b1, CTL, 8'h41);
    wt(1'b1, 1'b0, 80);
    chk("sticky activate", 8'h1, 8'(c < 40));
    wt(1'b1, 1'b1, 200);
    chk("pulse width", 8'(`WDH_RST_PULSE_CYC), 8'(c));
    do_rst(1'b0);
    wt(1'b0, 1'b1, 6000);
    rw(1'b1, CTL, 8'h80);
    wt(1'b1, 1'b0, 20);
    chk("software reset", 8'h1, 8'(c < 20));
    wt(1'b1, 1'b1, 200);
    hro <= 1'b1;
    u_wdh_cpu_model.halt(8'hff);
    wt(1'b1, 1'b0, 20);
    chk("halt reset", 8'h1, 8'(c < 20));
    hro <= 1'b0;
    do_rst(1'b1);
    wt(1'b0, 1'b1, 6000);
    rw(1'b1, CTL, 8'h41);
    wt(1'b1, 1'b0, 80);
    chk("hardware option", 8'h1, 8'(c < 40));
    print_verdict;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    print_verdict;
  end
endmodule // tb_wdh_watchdog

// [tb/wdh_cpu_model.sv]
// cpu-side model: register accesses, halt and wake events
`include "wdh_consts.vh"
module wdh_cpu_model (
  input  wire         clk,
  input  wire         ack,
  input  wire  [31:0] rdata,
  output logic        cyc,
  output logic        we,
  output logic [7:0]  adr,
  output logic [31:0] wdata,
  output logic [3:0]  sel,
  output logic [2:0]  ev
);
  timeunit 1ns;
  timeprecision 100ps;
  bit lost;
  initial begin
    cyc = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    wdata = 32'h0;
    sel = 4'h0;
    ev = 3'h0;
  end
  task automatic xfer(input logic w, input [7:0] a, input [7:0] d, output [7:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    wdata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    if (ack !== 1'b1) lost = 1'b1;
    q = rdata[7:0];
    cyc <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    // released lines flip so stale sampling cannot pass
    adr <= ~a;
    wdata <= ~wdata;
  endtask
  task automatic pulse(input [2:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 3'h0;
  endtask
  // refresh with the top bit forced high so the write cannot fire a reset, then halt
  task automatic halt(input [7:0] d);
    logic [7:0] q;
    xfer(1'b1, {`WDH_IDX_CONTROL, 2'b00}, d | 8'h40, q);
    pulse(3'b001);
  endtask
endmodule // wdh_cpu_model

// [tb/wdh_watchdog_chk.sv]
// port-level assertions for the halt-aware watchdog
`include "wdh_consts.vh"
module wdh_watchdog_chk #(
  parameter PRESCALE = 16384
) (
  input wire        CORE_CLK,
  input wire        NRST,
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_ACK_O,
  input wire [31:0] WB_DAT_O,
  input wire        HALT_EXEC,
  input wire        TIMEBASE_IRQ_ENABLE,
  input wire        HALT_RESET_OPTION,
  input wire        RESET_PIN_N,
  input wire        WDG_COUNTING
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [7:0] lo_cnt_r;
  // counts low samples of the reset pin so the pulse length can be judged
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST)
      lo_cnt_r <= 8'h0;
    else
      lo_cnt_r <= RESET_PIN_N ? 8'h0 : lo_cnt_r + 8'h1;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held");
  ack_resp_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack");
  ack_cause_a: assert property (WB_ACK_O |-> WB_CYC_I && WB_STB_I)
    else $error("stray ack");
  dat_high_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper read bits set");
  pulse_len_a: assert property ($rose(RESET_PIN_N) |-> lo_cnt_r == `WDH_RST_PULSE_CYC)
    else $error("reset pulse length");
  pulse_max_a: assert property (!RESET_PIN_N |-> lo_cnt_r < `WDH_RST_PULSE_CYC)
    else $error("reset pulse too long");
  halt_rst_a: assert property (
    HALT_EXEC && !TIMEBASE_IRQ_ENABLE && HALT_RESET_OPTION |-> ##[1:4] !RESET_PIN_N)
    else $error("no reset on halt");
  halt_hold_a: assert property (HALT_EXEC && TIMEBASE_IRQ_ENABLE |-> ##[1:3] !WDG_COUNTING)
    else $error("counter runs in clocked halt");
endmodule // wdh_watchdog_chk
bind wdh_watchdog wdh_watchdog_chk #(.PRESCALE(PRESCALE)) u_wdh_watchdog_chk (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .HALT_EXEC(HALT_EXEC),
  .TIMEBASE_IRQ_ENABLE(TIMEBASE_IRQ_ENABLE), .HALT_RESET_OPTION(HALT_RESET_OPTION),
  .RESET_PIN_N(RESET_PIN_N), .WDG_COUNTING(WDG_COUNTING));

// [verilog/wdh_consts.vh]
// constants for the halt-aware watchdog: offsets, fields, reset values and timing
`ifndef WDH_CONSTS_VH
`define WDH_CONSTS_VH

// register indexes; byte address is four times the index
`define WDH_IDX_CONTROL      6'h2a
`define WDH_IDX_STATUS       6'h2b

// watchdog_control fields
`define WDH_CTL_ACT_BIT      7
`define WDH_CTL_TOP_BIT      6
`define WDH_CTL_RESET        8'h7f
`define WDH_CNT_RESET        7'h7f
`define WDH_CNT_ROLL_FROM    7'h40

// status fields
`define WDH_ST_ACTIVE        0
`define WDH_ST_HW_OPTION     1
`define WDH_ST_HALT_STOPPED  2
`define WDH_ST_HALT_CLOCKED  3
`define WDH_ST_RESUME_WAIT   4
`define WDH_ST_RST_PULSE     5
`define WDH_ST_HALT_DEC      6

// timing
`define WDH_CLK_PERIOD_NS    5
`define WDH_PRESCALE_OSC     16384
`define WDH_RST_PULSE_NS     500
`define WDH_RST_PULSE_CYC    ((`WDH_RST_PULSE_NS + `WDH_CLK_PERIOD_NS - 1) / `WDH_CLK_PERIOD_NS)
`define WDH_RESUME_SHORT_CYC 256
`define WDH_RESUME_LONG_CYC  4096
`define WDH_TIMER_W          13

`endif

// [verilog/wdh_prescaler.v]
// free-running tick divider for the watchdog counter
module wdh_prescaler #(
  parameter PRESCALE = 16384
) (
  input  wire clk,
  input  wire rst_n,
  output reg  tick
);
  reg [14:0] div_r;

  // never cleared by software, so the first tick after a refresh may come early
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 15'h0000;
      tick  <= 1'b0;
    end else if (div_r == PRESCALE[14:0] - 15'h0001) begin
      div_r <= 15'h0000;
      tick  <= 1'b1;
    end else begin
      div_r <= div_r + 15'h0001;
      tick  <= 1'b0;
    end
  end
endmodule // wdh_prescaler

// [verilog/wdh_span_timer.v]
// one-shot down counter: busy for a loaded number of cycles, then a done pulse
`include "wdh_consts.vh"

module wdh_span_timer (
  input  wire                    clk,
  input  wire                    rst_n,
  input  wire                    start,
  input  wire [`WDH_TIMER_W-1:0] span,
  output wire                    busy,
  output reg                     done
);
  reg [`WDH_TIMER_W-1:0] left_r;

  assign busy = (left_r != {`WDH_TIMER_W{1'b0}});

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_r <= {`WDH_TIMER_W{1'b0}};
      done   <= 1'b0;
    end else if (start && !busy) begin
      left_r <= span;
      done   <= 1'b0;
    end else if (busy) begin
      left_r <= left_r - {{(`WDH_TIMER_W-1){1'b0}}, 1'b1};
      done   <= (left_r == {{(`WDH_TIMER_W-1){1'b0}}, 1'b1});
    end else begin
      done   <= 1'b0;
    end
  end
endmodule // wdh_span_timer

// [verilog/wdh_watchdog.v]
// halt-aware watchdog timer with a classic wishbone register slave
`include "wdh_consts.vh"

module wdh_watchdog #(
  parameter PRESCALE = `WDH_PRESCALE_OSC
) (
  input  wire        CORE_CLK,
  input  wire        NRST,
  // classic wishbone slave
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  // core and system signals
  input  wire        HALT_EXEC,
  input  wire        EXT_IRQ_WAKE,
  input  wire        OSC_IRQ_WAKE,
  input  wire        TIMEBASE_IRQ_ENABLE,
  input  wire        HALT_RESET_OPTION,
  input  wire        HW_WATCHDOG_OPTION,
  input  wire        RESUME_DELAY_LONG,
  output wire        RESET_PIN_N,
  output wire        WDG_COUNTING
);

  localparam [2:0] ST_RUN        = 3'h0;
  localparam [2:0] ST_HALT_DEC   = 3'h1;
  localparam [2:0] ST_HALT_STOP  = 3'h2;
  localparam [2:0] ST_HALT_CLK   = 3'h3;
  localparam [2:0] ST_RESUME     = 3'h4;

  // the timing macros are plain integers; keep the low timer bits on purpose
  localparam [31:0] RESUME_SHORT_W = `WDH_RESUME_SHORT_CYC;
  localparam [31:0] RESUME_LONG_W  = `WDH_RESUME_LONG_CYC;
  localparam [31:0] RST_PULSE_W    = `WDH_RST_PULSE_CYC;

  localparam [`WDH_TIMER_W-1:0] RESUME_SHORT = RESUME_SHORT_W[`WDH_TIMER_W-1:0];
  localparam [`WDH_TIMER_W-1:0] RESUME_LONG  = RESUME_LONG_W[`WDH_TIMER_W-1:0];
  localparam [`WDH_TIMER_W-1:0] RST_PULSE    = RST_PULSE_W[`WDH_TIMER_W-1:0];

  // register index decode, used by both the read mux and the write path
  function is_index;
    input [7:0] adr;
    input [5:0] idx;
    begin
      is_index = (adr[7:2] == idx) && (adr[1:0] == 2'b00);
    end
  endfunction

  function [`WDH_TIMER_W-1:0] resume_span;
    input long_sel;
    begin
      resume_span = long_sel ? RESUME_LONG : RESUME_SHORT;
    end
  endfunction

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [6:0]  cnt_r;
  reg  [6:0]  cnt_nxt;
  reg         act_r;
  reg         act_nxt;
  reg         hw_opt_r;
  reg         strap_done_r;
  reg         fire;
  reg         resume_start;
  reg         resume_start_boot;
  reg  [31:0] rd_data;

  wire        tick;
  wire        resume_busy;
  wire        resume_done;
  wire        pulse_busy;
  wire        wb_req;
  wire        wb_wr;
  wire        wr_ctl;
  wire        active;
  wire [6:0]  wr_cnt;
  wire        wr_act;
  wire        halt_plain;
  wire        halt_reset;
  wire        halt_clocked;
  wire        wake_any;
  wire        counting;

  // wishbone slave
  assign wb_req = WB_CYC_I && WB_STB_I;
  // write takes effect only at the edge where the master sees ack high
  assign wb_wr  = wb_req && WB_WE_I && WB_ACK_O;
  assign wr_ctl = wb_wr && WB_SEL_I[0] && is_index(WB_ADR_I, `WDH_IDX_CONTROL);
  assign wr_cnt = WB_DAT_I[6:0];
  assign wr_act = WB_DAT_I[`WDH_CTL_ACT_BIT];

  always @* begin
    rd_data = 32'h0000_0000;
    if (is_index(WB_ADR_I, `WDH_IDX_CONTROL)) begin
      rd_data[7:0] = {act_r, cnt_r};
    end else if (is_index(WB_ADR_I, `WDH_IDX_STATUS)) begin
      rd_data[`WDH_ST_ACTIVE]       = active;
      rd_data[`WDH_ST_HW_OPTION]    = hw_opt_r;
      rd_data[`WDH_ST_HALT_STOPPED] = (state_r == ST_HALT_STOP);
      rd_data[`WDH_ST_HALT_CLOCKED] = (state_r == ST_HALT_CLK);
      rd_data[`WDH_ST_RESUME_WAIT]  = (state_r == ST_RESUME);
      rd_data[`WDH_ST_RST_PULSE]    = pulse_busy;
      rd_data[`WDH_ST_HALT_DEC]     = (state_r == ST_HALT_DEC);
    end else begin
      rd_data = 32'h0000_0000;
    end
  end

  // every access, mapped or not, is acked one cycle after the request
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req && !WB_ACK_O;
      if (wb_req && !WB_ACK_O && !WB_WE_I) begin
        WB_DAT_O <= rd_data;
      end
    end
  end

  // option strap capture
  // the strap is sampled on the first edge after reset release, not by the reset
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      hw_opt_r     <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      hw_opt_r     <= HW_WATCHDOG_OPTION;
      strap_done_r <= 1'b1;
    end
  end

  assign active = act_r || hw_opt_r;

  // sub-blocks
  wdh_prescaler #(
    .PRESCALE (PRESCALE)
  ) u_prescaler (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .tick  (tick)
  );

  wdh_span_timer u_resume (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .start (resume_start || resume_start_boot),
    .span  (resume_span(RESUME_DELAY_LONG)),
    .busy  (resume_busy),
    .done  (resume_done)
  );

  // a fire while the pulse is running is absorbed into it
  wdh_span_timer u_rst_pulse (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .start (fire),
    .span  (RST_PULSE),
    .busy  (pulse_busy),
    .done  ()
  );

  assign RESET_PIN_N  = !pulse_busy;
  // no interrupt output exists; the reset pin is the only action
  assign WDG_COUNTING = counting;

  // halt decoding
  assign halt_clocked = HALT_EXEC && TIMEBASE_IRQ_ENABLE;
  assign halt_reset   = HALT_EXEC && !TIMEBASE_IRQ_ENABLE && HALT_RESET_OPTION;
  assign halt_plain   = HALT_EXEC && !TIMEBASE_IRQ_ENABLE && !HALT_RESET_OPTION;
  assign wake_any     = EXT_IRQ_WAKE || OSC_IRQ_WAKE;

  // slow and wait modes are not inputs: they leave the run state untouched
  assign counting = (state_r == ST_RUN) || (state_r == ST_HALT_DEC);

  // state machine
  always @* begin
    state_nxt    = state_r;
    resume_start = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (halt_clocked) begin
          state_nxt = ST_HALT_CLK;
        end else if (halt_plain) begin
          state_nxt = ST_HALT_DEC;
        end
      end
      ST_HALT_DEC: begin
        if (EXT_IRQ_WAKE) begin
          state_nxt    = ST_RESUME;
          resume_start = 1'b1;
        end else if (tick) begin
          state_nxt = ST_HALT_STOP;
        end
      end
      ST_HALT_STOP: begin
        if (EXT_IRQ_WAKE) begin
          state_nxt    = ST_RESUME;
          resume_start = 1'b1;
        end
      end
      ST_HALT_CLK: begin
        if (wake_any) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RESUME: begin
        if (resume_done) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // after any reset release the counter waits out the resume delay first
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= ST_RESUME;
    end else if (!strap_done_r) begin
      state_r <= ST_RESUME;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the delay after reset is started on the strap edge itself, the first edge after reset release
  reg boot_start_r;
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      boot_start_r <= 1'b1;
    end else begin
      boot_start_r <= 1'b0;
    end
  end

  // counter and activation
  always @* begin
    cnt_nxt = cnt_r;
    act_nxt = act_r;
    fire    = 1'b0;
    if (counting && tick) begin
      cnt_nxt = cnt_r - 7'h01;
      // the single decrement in plain halt may not fire
      if (state_r == ST_RUN && active && cnt_r == `WDH_CNT_ROLL_FROM) begin
        fire = 1'b1;
      end
    end
    if (wr_ctl) begin
      cnt_nxt = wr_cnt;
      act_nxt = act_r || wr_act;
      fire    = 1'b0;
      if ((act_r || wr_act || hw_opt_r) && !wr_cnt[`WDH_CTL_TOP_BIT]) begin
        fire = 1'b1;
      end
    end
    if (halt_reset && state_r == ST_RUN) begin
      fire = 1'b1;
    end
  end

  // reset alone clears activation, returning the disabled state after reset; halt leaves it set
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_r <= `WDH_CNT_RESET;
      act_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
    end
  end

  // hook the post-reset delay into the resume timer through the start port
  wire boot_kick;
  assign boot_kick = boot_start_r;

  always @* begin
    if (boot_kick) begin
      resume_start_boot = 1'b1;
    end else begin
      resume_start_boot = 1'b0;
    end
  end

endmodule // wdh_watchdog
